/* verif/event_source_model.sv */
`timescale 1ns/1ps
// Stand-in for the peripherals: turns bench commands into same-clock event lines
module event_source_model (
   input  wire logic                   i_clk,
   input  wire logic                   i_reset_n,
   input  wire logic [7:0]             i_pulse,
   input  wire logic                   i_gate_active,
   input  wire logic                   i_rx_full,
   input  wire logic                   i_tx_empty,
   input  wire irq_pkg::capcomp_mode_t i_mode1,
   input  wire irq_pkg::capcomp_mode_t i_mode2,
   output irq_pkg::periph_events_t     o_ev
);
   // Registered like a real peripheral, so every event leaves on a clean edge
   // A pulse lasts exactly as long as the bench holds its command
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_ev <= '0;
      end else begin
         o_ev.timer1_gate_active  <= i_gate_active;
         o_ev.adc_done            <= i_pulse[6];
         o_ev.uart_rx_full        <= i_rx_full;
         o_ev.uart_tx_empty       <= i_tx_empty;
         o_ev.sync_serial_done    <= i_pulse[3];
         o_ev.capcomp_unit1_event <= i_pulse[2];
         o_ev.capcomp_unit1_mode  <= i_mode1;
         o_ev.timer2_match        <= i_pulse[1];
         o_ev.timer1_overflow     <= i_pulse[0];
         o_ev.capcomp_unit2_event <= i_pulse[7];  // Bit 7 is free since the gate is a level
         o_ev.capcomp_unit2_mode  <= i_mode2;
      end
   end
endmodule

/* verif/peripheral_irq_flag_enable_tb_top.sv */
`timescale 1ns/1ps
module peripheral_irq_flag_enable_tb_top;
   logic                    i_clk = 1'h0;
   logic                    i_reset_n = 1'h0;
   irq_pkg::wb_req_t        wb = '0;
   irq_pkg::periph_events_t ev;
   logic                    ack;
   logic [31:0]             rdat;
   logic                    irq;
   logic                    ack_prev = 1'h0;
   logic [7:0]              pulse = 8'h00;
   logic                    gate = 1'h0;
   logic                    rx = 1'h0;
   logic                    tx = 1'h0;
   irq_pkg::capcomp_mode_t  mode1 = irq_pkg::CC_CAPTURE;
   irq_pkg::capcomp_mode_t  mode2 = irq_pkg::CC_COMPARE;
   int                      err_total = 0;
   int                      n_compared = 0;
   logic [15:0]             rng = 16'h49b5;
   logic [32:0]             exp_q[$];

   always #5 i_clk = ~i_clk;

   event_source_model u_event_source_model (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_pulse(pulse), .i_gate_active(gate), .i_rx_full(rx), .i_tx_empty(tx),
      .i_mode1(mode1), .i_mode2(mode2), .o_ev(ev));
   peripheral_irq_flag_enable u_peripheral_irq_flag_enable (.i_clk(i_clk),
      .i_reset_n(i_reset_n), .i_wb(wb), .i_ev(ev), .o_wb_ack(ack), .o_wb_dat(rdat),
      .o_peripheral_irq(irq));

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // One classic single cycle; the expected read data is noted for the monitor
   task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] d,
                      input logic [7:0] exp, input logic [3:0] byte_en = 4'hf);
      @(posedge i_clk);
      wb <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: adr, sel: byte_en, dat: {24'h0, d}};
      exp_q.push_back({~we, 24'h0, exp});
      // No local limit: only the watchdog may end a wait for ack
      do begin
         @(posedge i_clk);
      end while (ack !== 1'h1);
      wb <= '0;
   endtask

   // Pulse selected events for one cycle, then let them reach the flags
   task automatic fire(input logic [7:0] m);
      @(posedge i_clk);
      pulse <= m;
      @(posedge i_clk);
      pulse <= 8'h00;
      repeat (3) @(posedge i_clk);
   endtask

   task automatic irq_is(input logic e);
      repeat (3) @(posedge i_clk);
      check("irq", {31'h0, e}, {31'h0, irq});
   endtask

   // Monitor: each ack retires the oldest note; reads compare their data
   always @(posedge i_clk) begin
      logic [32:0] e;
      // Ack is a single-cycle pulse, so it must be low the cycle after
      if (ack_prev === 1'h1) check("ack pulse", 32'h0, {31'h0, ack});
      if (ack === 1'h1) begin
         if (exp_q.size() == 0) begin
            check("unexpected ack", 32'h0, 32'h1);
         end else begin
            e = exp_q.pop_front();
            if (e[32]) check("read data", {24'h0, e[7:0]}, rdat);
         end
      end
      ack_prev <= ack;
   end

   // Watchdog: far beyond the few hundred cycles the tests need
   initial begin
      #200000;
      check("watchdog", 32'h0, 32'h1);
      print_verdict();
   end

   initial begin
      repeat (6) @(posedge i_clk);
      i_reset_n <= 1'h1;
      bus(1'h0, irq_pkg::OFS_ENABLE_1, 8'h00, 8'h00);
      bus(1'h0, irq_pkg::OFS_ENABLE_2, 8'h00, 8'h00);
      bus(1'h0, irq_pkg::OFS_REQUEST_1, 8'h00, 8'h00);
      bus(1'h0, irq_pkg::OFS_REQUEST_2, 8'h00, 8'h00);
      bus(1'h0, irq_pkg::OFS_INT_CONTROL, 8'h00, 8'h00);
      bus(1'h0, irq_pkg::OFS_CORE_OPTIONS, 8'h00, 8'hff);
      bus(1'h1, 8'h18, 8'hff, 8'h00);
      bus(1'h0, 8'h18, 8'h00, 8'h00);
      $display("test reset values done");
      // Access kinds: unimplemented and read-only bits must not stick
      bus(1'h1, irq_pkg::OFS_ENABLE_1, 8'ha5, 8'h00);
      bus(1'h0, irq_pkg::OFS_ENABLE_1, 8'h00, 8'ha5);
      // Lowest byte lane off: the write is acked but dropped
      bus(1'h1, irq_pkg::OFS_ENABLE_1, 8'h3c, 8'h00, 4'he);
      bus(1'h0, irq_pkg::OFS_ENABLE_1, 8'h00, 8'ha5);
      bus(1'h1, irq_pkg::OFS_ENABLE_2, 8'hff, 8'h00);
      bus(1'h0, irq_pkg::OFS_ENABLE_2, 8'h00, 8'h01);
      bus(1'h1, irq_pkg::OFS_REQUEST_2, 8'hff, 8'h00);
      bus(1'h0, irq_pkg::OFS_REQUEST_2, 8'h00, 8'h01);
      bus(1'h1, irq_pkg::OFS_REQUEST_1, 8'hff, 8'h00);
      bus(1'h0, irq_pkg::OFS_REQUEST_1, 8'h00, 8'hcf);
      bus(1'h1, irq_pkg::OFS_REQUEST_1, 8'h00, 8'h00);
      bus(1'h0, irq_pkg::OFS_REQUEST_1, 8'h00, 8'h00);
      bus(1'h1, irq_pkg::OFS_REQUEST_2, 8'h00, 8'h00);
      bus(1'h1, irq_pkg::OFS_ENABLE_1, 8'h00, 8'h00);
      $display("test access kinds done");
      // Capture/compare units in every mode, with enable register 1 clear and only the unit 2 enable set
      for (int m = 0; m < 4; m++) begin
         @(posedge i_clk);
         mode1 <= irq_pkg::capcomp_mode_t'(m[1:0]);
         mode2 <= irq_pkg::capcomp_mode_t'(m[1:0]);
         fire(8'h84);
         bus(1'h0, irq_pkg::OFS_REQUEST_1, 8'h00, (m < 2) ? 8'h04 : 8'h00);
         bus(1'h0, irq_pkg::OFS_REQUEST_2, 8'h00, (m < 2) ? 8'h01 : 8'h00);
         bus(1'h1, irq_pkg::OFS_REQUEST_1, 8'h00, 8'h00);
         bus(1'h1, irq_pkg::OFS_REQUEST_2, 8'h00, 8'h00);
      end
      @(posedge i_clk);
      mode1 <= irq_pkg::CC_CAPTURE;
      mode2 <= irq_pkg::CC_COMPARE;
      for (int b = 0; b < 7; b++) begin
         if (b == 2 || b == 4 || b == 5) continue;
         fire(8'h01 << b);
         bus(1'h0, irq_pkg::OFS_REQUEST_1, 8'h00, 8'h01 << b);
         irq_is(1'h0);
         bus(1'h1, irq_pkg::OFS_REQUEST_1, 8'h00, 8'h00);
      end
      $display("test event flags done");
      // Level flags: receive and transmit follow their levels; the timer1 gate flag sets when the gate goes inactive
      @(posedge i_clk);
      rx <= 1'h1;
      tx <= 1'h1;
      gate <= 1'h1;
      repeat (4) @(posedge i_clk);
      bus(1'h0, irq_pkg::OFS_REQUEST_1, 8'h00, 8'h30);
      bus(1'h1, irq_pkg::OFS_REQUEST_1, 8'h00, 8'h00);
      bus(1'h0, irq_pkg::OFS_REQUEST_1, 8'h00, 8'h30);
      @(posedge i_clk);
      rx <= 1'h0;
      tx <= 1'h0;
      gate <= 1'h0;
      repeat (4) @(posedge i_clk);
      bus(1'h0, irq_pkg::OFS_REQUEST_1, 8'h00, 8'h80);
      @(posedge i_clk);
      gate <= 1'h1;
      repeat (4) @(posedge i_clk);
      bus(1'h0, irq_pkg::OFS_REQUEST_1, 8'h00, 8'h00);
      $display("test level flags done");
      // Request gating: a pending flag waits for both master enables
      bus(1'h1, irq_pkg::OFS_REQUEST_1, 8'h00, 8'h00);
      bus(1'h1, irq_pkg::OFS_ENABLE_1, 8'h40, 8'h00);
      fire(8'h40);
      irq_is(1'h0);
      bus(1'h1, irq_pkg::OFS_INT_CONTROL, 8'h40, 8'h00);
      irq_is(1'h0);
      bus(1'h1, irq_pkg::OFS_INT_CONTROL, 8'h80, 8'h00);
      irq_is(1'h0);
      bus(1'h1, irq_pkg::OFS_INT_CONTROL, 8'hc0, 8'h00);
      irq_is(1'h1);
      bus(1'h1, irq_pkg::OFS_ENABLE_1, 8'h00, 8'h00);
      irq_is(1'h0);
      fire(8'h80);
      irq_is(1'h1);
      bus(1'h1, irq_pkg::OFS_REQUEST_2, 8'h00, 8'h00);
      irq_is(1'h0);
      $display("test request gating done");
      // Random enables against random event bursts
      for (int k = 0; k < 12; k++) begin
         rng = lfsr_next(rng);
         bus(1'h1, irq_pkg::OFS_REQUEST_1, 8'h00, 8'h00);
         bus(1'h1, irq_pkg::OFS_ENABLE_1, rng[15:8], 8'h00);
         fire(rng[7:0] & 8'h4f);
         bus(1'h0, irq_pkg::OFS_REQUEST_1, 8'h00, rng[7:0] & 8'h4f);
         irq_is(|(rng[15:8] & rng[7:0] & 8'h4f));
      end
      $display("test random requests done");
      repeat (3) @(posedge i_clk);
      print_verdict();
   end
endmodule

/* verilog/irq_pkg.sv */
package irq_pkg;

   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W  = 8;

   // Register byte offsets on the bus
   localparam logic [ADDR_W-1:0] OFS_ENABLE_1     = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_ENABLE_2     = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_REQUEST_1    = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_REQUEST_2    = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_INT_CONTROL  = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_CORE_OPTIONS = 8'h14;

   // Source positions shared by enable and request registers
   localparam int BIT_TIMER1_GATE  = 7;
   localparam int BIT_ADC          = 6;
   localparam int BIT_UART_RX      = 5;
   localparam int BIT_UART_TX      = 4;
   localparam int BIT_SYNC_SERIAL  = 3;
   localparam int BIT_CAPCOMP_1    = 2;
   localparam int BIT_TIMER2_MATCH = 1;
   localparam int BIT_TIMER1_OVF   = 0;
   localparam int BIT_CAPCOMP_2    = 0;

   // Interrupt control fields
   localparam int BIT_GLOBAL_EN = 7;
   localparam int BIT_PERIPH_EN = 6;

   // Reset values
   localparam logic [REG_W-1:0] RST_ENABLE_1     = 8'h00;
   localparam logic [REG_W-1:0] RST_ENABLE_2     = 8'h00;
   localparam logic [REG_W-1:0] RST_REQUEST_1    = 8'h00;
   localparam logic [REG_W-1:0] RST_REQUEST_2    = 8'h00;
   localparam logic [REG_W-1:0] RST_INT_CONTROL  = 8'h00;
   localparam logic [REG_W-1:0] RST_CORE_OPTIONS = 8'hff;

   // Implemented bits of the second enable and request registers
   localparam logic [REG_W-1:0] MASK_SECOND = 8'h01;

   // Capture/compare unit operating mode
   typedef enum logic [1:0] {
      CC_CAPTURE = 2'b00,
      CC_COMPARE = 2'b01,
      CC_PWM     = 2'b10,
      CC_OFF     = 2'b11
   } capcomp_mode_t;

   // Classic Wishbone request from the master
   typedef struct packed {
      logic              cyc;
      logic              stb;
      logic              we;
      logic [ADDR_W-1:0] adr;
      logic [3:0]        sel;
      logic [DATA_W-1:0] dat;
   } wb_req_t;

   // Peripheral event sources, all in the core clock domain
   typedef struct packed {
      logic          timer1_gate_active;
      logic          adc_done;
      logic          uart_rx_full;
      logic          uart_tx_empty;
      logic          sync_serial_done;
      logic          capcomp_unit1_event;
      capcomp_mode_t capcomp_unit1_mode;
      logic          timer2_match;
      logic          timer1_overflow;
      logic          capcomp_unit2_event;
      capcomp_mode_t capcomp_unit2_mode;
   } periph_events_t;

endpackage

/* verilog/peripheral_irq_flag_enable.sv */
`timescale 1ns/1ps
// What this block does
// - No peripheral request leaves the block while the peripheral master enable is clear.
// - Every request flag sets on its event whatever any enable bit holds.
// - Enable register 1 holds eight read/write enables, gate down to timer1 overflow, reset 0.
// - Enable register 2 holds only the unit 2 enable at bit 0; bits 7..1 read zero.
// - Request register 1 uses the same bit order as enable register 1 and resets to zero.
// - The receive flag at bit 5 is read-only and follows the receive-buffer-full level.
// - The transmit flag at bit 4 is read-only and follows the transmit-buffer-empty level.
// - The gate flag at bit 7 reads 1 once the timer1 gate goes inactive, 0 while active.
// - The converter flag at bit 6 sets on conversion done and holds until written zero.
// - The serial port flag at bit 3 sets on transfer done and holds until cleared.
// - The unit 1 flag at bit 2 sets on capture or compare events and never in PWM mode.
// - The timer2 flag at bit 1 sets on a period match and holds until cleared.
// - The timer1 overflow flag at bit 0 sets on overflow and holds until written zero.
// - Request register 2 holds only the unit 2 flag at bit 0, same modes as unit 1.
// - With the global enable clear no interrupt goes out; pending flags wait for it.
module peripheral_irq_flag_enable (
   input  wire logic                   i_clk,
   input  wire logic                   i_reset_n,
   input  wire irq_pkg::wb_req_t       i_wb,
   input  wire irq_pkg::periph_events_t i_ev,
   output logic                        o_wb_ack,
   output logic [irq_pkg::DATA_W-1:0]  o_wb_dat,
   output logic                        o_peripheral_irq
);

   logic [irq_pkg::REG_W-1:0] enable_1;
   logic [irq_pkg::REG_W-1:0] enable_2;
   logic [irq_pkg::REG_W-1:0] request_1;
   logic [irq_pkg::REG_W-1:0] request_2;
   logic [irq_pkg::REG_W-1:0] int_control;
   logic [irq_pkg::REG_W-1:0] core_options;
   logic                      gate_active_q;
   logic                      access;
   logic                      wr;
   logic                      wr_req_1;
   logic                      wr_req_2;
   logic [irq_pkg::REG_W-1:0] wbyte;
   logic [irq_pkg::REG_W-1:0] set_1;
   logic [irq_pkg::REG_W-1:0] clear_1;
   logic                      set_2;
   logic [irq_pkg::REG_W-1:0] next_rdata;
   logic                      next_irq;

   // A new access is one not yet acknowledged; ack drops after one cycle
   assign access   = i_wb.cyc & i_wb.stb & ~o_wb_ack;
   assign wr       = access & i_wb.we & i_wb.sel[0];
   assign wr_req_1 = wr & (i_wb.adr == irq_pkg::OFS_REQUEST_1);
   assign wr_req_2 = wr & (i_wb.adr == irq_pkg::OFS_REQUEST_2);
   assign wbyte    = i_wb.dat[irq_pkg::REG_W-1:0];

   // Single-cycle acknowledge, also for unmapped addresses
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_wb_ack <= 1'b0;
      end else begin
         o_wb_ack <= access;
      end
   end

   // Enable registers; only bit 0 of the second exists
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         enable_1 <= irq_pkg::RST_ENABLE_1;
         enable_2 <= irq_pkg::RST_ENABLE_2;
      end else if (wr && i_wb.adr == irq_pkg::OFS_ENABLE_1) begin
         enable_1 <= wbyte;
      end else if (wr && i_wb.adr == irq_pkg::OFS_ENABLE_2) begin
         enable_2 <= wbyte & irq_pkg::MASK_SECOND;
      end
   end

   // Interrupt control and core options are plain storage here
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         int_control  <= irq_pkg::RST_INT_CONTROL;
         core_options <= irq_pkg::RST_CORE_OPTIONS;
      end else if (wr && i_wb.adr == irq_pkg::OFS_INT_CONTROL) begin
         int_control <= wbyte;
      end else if (wr && i_wb.adr == irq_pkg::OFS_CORE_OPTIONS) begin
         core_options <= wbyte;
      end
   end

   // Previous gate level, used to see the end of an acquisition
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         gate_active_q <= 1'b0;
      end else begin
         gate_active_q <= i_ev.timer1_gate_active;
      end
   end

   // Event decode; enables play no part in setting a flag
   always_comb begin
      set_1   = '0;
      clear_1 = '0;
      set_1[irq_pkg::BIT_TIMER1_GATE]   = gate_active_q & ~i_ev.timer1_gate_active;
      clear_1[irq_pkg::BIT_TIMER1_GATE] = i_ev.timer1_gate_active;
      set_1[irq_pkg::BIT_ADC]           = i_ev.adc_done;
      set_1[irq_pkg::BIT_UART_RX]       = i_ev.uart_rx_full;
      set_1[irq_pkg::BIT_UART_TX]       = i_ev.uart_tx_empty;
      set_1[irq_pkg::BIT_SYNC_SERIAL]   = i_ev.sync_serial_done;
      set_1[irq_pkg::BIT_CAPCOMP_1]     = i_ev.capcomp_unit1_event
         & (i_ev.capcomp_unit1_mode == irq_pkg::CC_CAPTURE
            | i_ev.capcomp_unit1_mode == irq_pkg::CC_COMPARE);
      set_1[irq_pkg::BIT_TIMER2_MATCH]  = i_ev.timer2_match;
      set_1[irq_pkg::BIT_TIMER1_OVF]    = i_ev.timer1_overflow;
   end

   // Unit 2 follows the same mode gating as unit 1
   assign set_2 = i_ev.capcomp_unit2_event
      & (i_ev.capcomp_unit2_mode == irq_pkg::CC_CAPTURE
         | i_ev.capcomp_unit2_mode == irq_pkg::CC_COMPARE);

   // Request register 1: sticky flags, and two mirrored buffer levels
   for (genvar i = 0; i < irq_pkg::REG_W; i++) begin : g_req1
      if (i == irq_pkg::BIT_UART_RX || i == irq_pkg::BIT_UART_TX) begin : g_level
         logic level_q;
         // The UART owns these levels, so software writes are ignored
         always_ff @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               level_q <= irq_pkg::RST_REQUEST_1[i];
            end else begin
               level_q <= set_1[i];
            end
         end
         // These two bits of the flag vector are driven by level_q; the other bits come from sticky_flag
         assign request_1[i] = level_q;
      end else begin : g_sticky
         sticky_flag u_flag (
            .i_clk     (i_clk),
            .i_reset_n (i_reset_n),
            .i_set     (set_1[i]),
            .i_clear   (clear_1[i]),
            .i_write   (wr_req_1),
            .i_wdata   (wbyte[i]),
            .o_flag    (request_1[i])
         );
      end
   end

   // Request register 2: only bit 0 is built
   sticky_flag u_flag_unit2 (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_set     (set_2),
      .i_clear   (1'b0),
      .i_write   (wr_req_2),
      .i_wdata   (wbyte[irq_pkg::BIT_CAPCOMP_2]),
      .o_flag    (request_2[irq_pkg::BIT_CAPCOMP_2])
   );
   assign request_2[irq_pkg::REG_W-1:1] = '0;

   // Read decode; unmapped addresses read zero
   always_comb begin
      if (i_wb.adr == irq_pkg::OFS_ENABLE_1) begin
         next_rdata = enable_1;
      end else if (i_wb.adr == irq_pkg::OFS_ENABLE_2) begin
         next_rdata = enable_2;
      end else if (i_wb.adr == irq_pkg::OFS_REQUEST_1) begin
         next_rdata = request_1;
      end else if (i_wb.adr == irq_pkg::OFS_REQUEST_2) begin
         next_rdata = request_2;
      end else if (i_wb.adr == irq_pkg::OFS_INT_CONTROL) begin
         next_rdata = int_control;
      end else if (i_wb.adr == irq_pkg::OFS_CORE_OPTIONS) begin
         next_rdata = core_options;
      end else begin
         next_rdata = '0;
      end
   end

   // Read data is captured with the ack and held until the next read access
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_wb_dat <= '0;
      end else if (access && !i_wb.we) begin
         o_wb_dat <= {{(irq_pkg::DATA_W-irq_pkg::REG_W){1'b0}}, next_rdata};
      end
   end

   // Request to the core; a flag left pending while disabled fires on re-enable
   assign next_irq = int_control[irq_pkg::BIT_GLOBAL_EN]
      & int_control[irq_pkg::BIT_PERIPH_EN]
      & (|((request_1 & enable_1) | (request_2 & enable_2)));

   // Registered so the core sees a glitch-free level
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_peripheral_irq <= 1'b0;
      end else begin
         o_peripheral_irq <= next_irq;
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);

   sequence s_new_access;
      i_wb.cyc && i_wb.stb && !o_wb_ack;
   endsequence

   sequence s_ack_pulse;
      o_wb_ack ##1 !o_wb_ack;
   endsequence

   property p_ack_timing;
      s_new_access |=> s_ack_pulse;
   endproperty
   a_ack_timing: assert property (p_ack_timing) else $error("ack not one cycle");

   property p_master_gate;
      !int_control[irq_pkg::BIT_PERIPH_EN] |=> !o_peripheral_irq;
   endproperty
   a_master_gate: assert property (p_master_gate) else $error("irq with master off");

   property p_global_gate;
      !int_control[irq_pkg::BIT_GLOBAL_EN] |=> !o_peripheral_irq;
   endproperty
   a_global_gate: assert property (p_global_gate) else $error("irq with global off");

   property p_irq_combine;
      (int_control[irq_pkg::BIT_GLOBAL_EN] && int_control[irq_pkg::BIT_PERIPH_EN]
         && |(request_1 & enable_1)) |=> o_peripheral_irq;
   endproperty
   a_irq_combine: assert property (p_irq_combine) else $error("enabled flag no irq");

   property p_adc_set;
      i_ev.adc_done |=> request_1[irq_pkg::BIT_ADC];
   endproperty
   a_adc_set: assert property (p_adc_set) else $error("adc flag not set");

   property p_adc_hold;
      request_1[irq_pkg::BIT_ADC] && !wr_req_1 |=> request_1[irq_pkg::BIT_ADC];
   endproperty
   a_adc_hold: assert property (p_adc_hold) else $error("adc flag lost");

   property p_rx_level;
      request_1[irq_pkg::BIT_UART_RX] == $past(i_ev.uart_rx_full);
   endproperty
   a_rx_level: assert property (p_rx_level) else $error("rx flag wrong");

   property p_tx_level;
      ##1 request_1[irq_pkg::BIT_UART_TX] == $past(i_ev.uart_tx_empty);
   endproperty
   a_tx_level: assert property (p_tx_level) else $error("tx flag wrong");

   property p_gate_flag;
      $fell(i_ev.timer1_gate_active) |=> request_1[irq_pkg::BIT_TIMER1_GATE]
         until i_ev.timer1_gate_active || wr_req_1;
   endproperty
   a_gate_flag: assert property (p_gate_flag) else $error("gate flag wrong");

   property p_gate_active;
      i_ev.timer1_gate_active |=> !request_1[irq_pkg::BIT_TIMER1_GATE];
   endproperty
   a_gate_active: assert property (p_gate_active) else $error("gate flag while active");

   property p_pwm_quiet;
      i_ev.capcomp_unit1_mode == irq_pkg::CC_PWM && !request_1[irq_pkg::BIT_CAPCOMP_1]
         && !wr_req_1 |=> !request_1[irq_pkg::BIT_CAPCOMP_1];
   endproperty
   a_pwm_quiet: assert property (p_pwm_quiet) else $error("unit1 flag in pwm");

   property p_second_regs;
      ##1 (request_2[irq_pkg::REG_W-1:1] == '0) && (enable_2[irq_pkg::REG_W-1:1] == '0);
   endproperty
   a_second_regs: assert property (p_second_regs) else $error("upper bits set");

   property p_unit2_set;
      i_ev.capcomp_unit2_event && i_ev.capcomp_unit2_mode == irq_pkg::CC_COMPARE
         |=> request_2[irq_pkg::BIT_CAPCOMP_2];
   endproperty
   a_unit2_set: assert property (p_unit2_set) else $error("unit2 flag not set");

   property p_enable_write;
      wr && i_wb.adr == irq_pkg::OFS_ENABLE_1 |=> enable_1 == $past(wbyte);
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable write lost");

   property p_ovf_set;
      i_ev.timer1_overflow ##1 !wr_req_1 |=> request_1[irq_pkg::BIT_TIMER1_OVF];
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow flag lost");

   property p_serial_set;
      i_ev.sync_serial_done |=> request_1[irq_pkg::BIT_SYNC_SERIAL];
   endproperty
   a_serial_set: assert property (p_serial_set) else $error("serial flag");

   property p_serial_hold;
      request_1[irq_pkg::BIT_SYNC_SERIAL] && !wr_req_1 |=> request_1[irq_pkg::BIT_SYNC_SERIAL];
   endproperty
   a_serial_hold: assert property (p_serial_hold) else $error("serial flag lost");

   property p_timer2_set;
      i_ev.timer2_match |=> request_1[irq_pkg::BIT_TIMER2_MATCH];
   endproperty
   a_timer2_set: assert property (p_timer2_set) else $error("timer2 flag");

   property p_unit1_capture;
      i_ev.capcomp_unit1_event && i_ev.capcomp_unit1_mode == irq_pkg::CC_CAPTURE
         |=> request_1[irq_pkg::BIT_CAPCOMP_1];
   endproperty
   a_unit1_capture: assert property (p_unit1_capture) else $error("unit1 flag");

   // The second register reaches the core through the same two gates
   property p_unit2_combine;
      (int_control[irq_pkg::BIT_GLOBAL_EN] && int_control[irq_pkg::BIT_PERIPH_EN]
         && request_2[irq_pkg::BIT_CAPCOMP_2] && enable_2[irq_pkg::BIT_CAPCOMP_2])
         |=> o_peripheral_irq;
   endproperty
   a_unit2_combine: assert property (p_unit2_combine) else $error("unit2 no irq");

endmodule

/* verilog/sticky_flag.sv */
`timescale 1ns/1ps
// One request flag: hardware set beats any clear in the same cycle
module sticky_flag (
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   input  wire logic i_set,
   input  wire logic i_clear,
   input  wire logic i_write,
   input  wire logic i_wdata,
   output logic      o_flag
);

   // Set first so an event coinciding with a software clear is kept
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_flag <= 1'b0;
      end else if (i_set) begin
         o_flag <= 1'b1;
      end else if (i_clear) begin
         o_flag <= 1'b0;
      end else if (i_write) begin
         o_flag <= i_wdata;
      end
   end

endmodule
